// file: hdl/baud_gen_pkg.sv
// package for the fractional baud generator: register map, fields, reset values
// assumes an apb slave on pclk with word-aligned 32-bit registers
`default_nettype none

package baud_gen_pkg;
  localparam logic [11:0] ctrl_offset     = 12'h000;
  localparam logic [11:0] frac_offset     = 12'h004;
  localparam logic [11:0] status_offset   = 12'h008;
  localparam int          enable_bit      = 7;
  localparam int          exp_msb         = 2;
  localparam int          exp_lsb         = 0;
  localparam logic [7:0]  ctrl_reset      = 8'h00;
  localparam logic [7:0]  frac_reset      = 8'h00;
  localparam logic [7:0]  ctrl_write_mask = 8'h87;
  localparam logic [7:0]  frac_base       = 8'h40;

  typedef struct packed {
    logic       rate_double;
    logic       tx_timer2_sel;
    logic       rx_timer2_sel;
    logic       timer1_tick;
    logic       timer2_tx_tick;
    logic       timer2_rx_tick;
  } legacy_src_t;

  typedef struct packed {
    logic       tx_tick;
    logic       rx_tick;
    logic       from_generator;
  } baud_out_t;
endpackage : baud_gen_pkg

`default_nettype wire

// file: hdl/frac_divider.sv
// fractional divider core: prescale by 2^exp, then accumulate 2 per prescaled
// clock against a modulus of (fraction + 64), ticking on each wrap
// assumes exp and fraction are steady except on software writes
`default_nettype none

module frac_divider
  import baud_gen_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [2:0] exponent,
  input  wire logic [7:0] fraction,
  output logic            tick
);
  logic [6:0] pre_r;
  logic [8:0] acc_r;
  logic       tick_r;
  wire  [6:0] pre_mask = 7'((8'h01 << exponent) - 8'h01);
  wire        pre_hit  = ((pre_r & pre_mask) == pre_mask);
  wire  [8:0] modulus  = {1'b0, fraction} + {1'b0, frac_base};
  wire  [8:0] acc_sum  = acc_r + 9'h002;
  wire        wrap     = pre_hit && (acc_sum >= modulus);

  // two per prescaled clock gives the factor 2 in the rate; the remainder carries
  // over, so the average rate is exact even when the modulus is odd
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r  <= 7'h00;
      acc_r  <= 9'h000;
      tick_r <= 1'b0;
    end else if (!run) begin
      pre_r  <= 7'h00;
      acc_r  <= 9'h000;
      tick_r <= 1'b0;
    end else begin
      pre_r  <= pre_hit ? 7'h00 : pre_r + 7'h01;
      acc_r  <= !pre_hit ? acc_r : (wrap ? acc_sum - modulus : acc_sum);
      tick_r <= wrap;
    end
  end
  assign tick = tick_r;

  // with exponent 0 and fraction 0 the tick repeats every 32 clocks; the count
  // parks at all ones while stopped so the first tick after a start is not judged
  logic [5:0] gap_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_r <= 6'h3F;
    else if (!run) gap_r <= 6'h3F;
    else if (tick_r) gap_r <= 6'h00;
    else if (gap_r != 6'h3F) gap_r <= gap_r + 6'h01;
  end
  min_period_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run && $past(run) && tick_r && exponent == 3'h0 && fraction == 8'h00
     && $stable(exponent) && $stable(fraction) && gap_r != 6'h3F)
    |-> gap_r == 6'h1F)
    else $error("tick spacing wrong for exp 0 fraction 0");
  prescale_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run && !pre_hit) |=> !tick_r)
    else $error("tick without prescaler hit");
endmodule : frac_divider

`default_nettype wire

// file: hdl/fractional_uart_baud_generator.sv
// top: apb register file and baud source selection for the uart shift logic
// assumes pclk is the core clock and legacy ticks come in synchronous to it
//
// Implementation choices: the address map and the APB interface to the registers.
`default_nettype none

module fractional_uart_baud_generator
  import baud_gen_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire legacy_src_t legacy,
  output baud_out_t        baud,
  output logic             timers_free
);
  ////////////////////////////////////////////////////////////////////////////
  // decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction : hit

  wire setup     = psel && !penable;
  wire access    = psel && penable;
  wire ctrl_sel  = hit(paddr, ctrl_offset);
  wire frac_sel  = hit(paddr, frac_offset);
  wire stat_sel  = hit(paddr, status_offset);
  wire mapped    = ctrl_sel || frac_sel || stat_sel;
  wire wr_ok     = access && pready && pwrite && pstrb[0];
  wire ctrl_wr   = wr_ok && ctrl_sel;
  wire frac_wr   = wr_ok && frac_sel;

  logic [7:0] ctrl_r;
  logic [7:0] frac_r;
  wire        gen_on   = ctrl_r[enable_bit];
  wire  [2:0] exponent = ctrl_r[exp_msb:exp_lsb];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  // status is read-only and writes to it are refused with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= ctrl_reset;
      frac_r <= frac_reset;
    end else begin
      if (ctrl_wr) ctrl_r <= pwdata[7:0] & ctrl_write_mask;
      if (frac_wr) frac_r <= pwdata[7:0];
    end
  end

  // no wait state: pready rises in the first access cycle, so every transfer
  // takes exactly setup plus one access cycle
  logic [31:0] prdata_nxt;
  logic        err_nxt;
  logic        gen_tick;
  logic        tick_seen_r;
  assign prdata_nxt = ctrl_sel ? {24'h000000, ctrl_r} :
                      frac_sel ? {24'h000000, frac_r} :
                      stat_sel ? {30'h0, tick_seen_r, gen_on} : 32'h00000000;
  assign err_nxt    = !mapped || (stat_sel && pwrite);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup && err_nxt;
      prdata  <= setup && !pwrite ? prdata_nxt : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fractional divider
  frac_divider u_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (gen_on),
    .exponent (exponent),
    .fraction (frac_r),
    .tick     (gen_tick)
  );

  // sticky until the next status read; set wins over the clear
  wire stat_rd = access && pready && !pwrite && stat_sel;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_seen_r <= 1'b0;
    else if (gen_tick) tick_seen_r <= 1'b1;
    else if (stat_rd) tick_seen_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection
  // legacy path: rate doubling halves the timer 1 prescale; select bits pick timer 2
  logic t1_half_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) t1_half_r <= 1'b0;
    else if (legacy.timer1_tick) t1_half_r <= !t1_half_r;
  end
  wire t1_tick = legacy.timer1_tick && (legacy.rate_double || t1_half_r);
  wire leg_tx  = legacy.tx_timer2_sel ? legacy.timer2_tx_tick : t1_tick;
  wire leg_rx  = legacy.rx_timer2_sel ? legacy.timer2_rx_tick : t1_tick;

  // a generator tick is one 16x-oversample clock shared by tx and rx
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud        <= '0;
      timers_free <= 1'b0;
    end else begin
      baud.tx_tick        <= gen_on ? gen_tick : leg_tx;
      baud.rx_tick        <= gen_on ? gen_tick : leg_rx;
      baud.from_generator <= gen_on;
      timers_free         <= gen_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence apb_setup_s;
    psel && !penable;
  endsequence
  sequence apb_done_s;
    psel && penable && pready;
  endsequence

  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup_s |=> apb_done_s)
    else $error("apb answer not one cycle after setup");
  ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_wr && !pslverr) |=> ctrl_r == ($past(pwdata[7:0]) & ctrl_write_mask))
    else $error("control write not stored");
  frac_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    frac_wr |=> frac_r == $past(pwdata[7:0]))
    else $error("fraction write not stored");
  legacy_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gen_on && !gen_tick) |=> !baud.tx_tick && !baud.rx_tick)
    else $error("legacy tick leaked while generator on");
  legacy_path_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!gen_on && legacy.tx_timer2_sel && legacy.timer2_tx_tick) |=> baud.tx_tick)
    else $error("legacy tx tick lost");
  timers_free_a: assert property (@(posedge pclk) disable iff (!presetn)
    timers_free == $past(gen_on))
    else $error("timers free flag wrong");
  gen_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gen_on && $past(gen_on) && gen_tick) |=> baud.tx_tick && baud.rx_tick)
    else $error("generator tick not forwarded");
  unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_setup_s and !mapped) |=> pslverr)
    else $error("unmapped access not refused");
  reset_off_a: assert property (@(posedge pclk)
    $rose(presetn) |-> !gen_on)
    else $error("generator enabled after reset");
endmodule : fractional_uart_baud_generator

`default_nettype wire

// file: sim/uart_shift_model.sv
// uart shift logic stand-in: measures the spacing of baud ticks
// assumes ticks are one-cycle pulses synchronous to pclk
`default_nettype none

module uart_shift_model
  import baud_gen_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire baud_out_t baud,
  output logic [15:0]    gap,
  output logic [15:0]    ticks,
  output logic           split
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt_r;
  ////////////////////////////////////////////////////////////////////////////
  // with the generator on both shifters run at one rate, so their ticks must coincide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      gap   <= 16'h0000;
      ticks <= 16'h0000;
      split <= 1'b0;
    end else begin
      cnt_r <= baud.tx_tick ? 16'h0000 : cnt_r + 16'h0001;
      if (baud.tx_tick) begin
        gap   <= cnt_r + 16'h0001;
        ticks <= ticks + 16'h0001;
      end
      if (baud.from_generator && baud.tx_tick !== baud.rx_tick) begin
        split <= 1'b1;
      end
    end
  end
endmodule : uart_shift_model

`default_nettype wire

// file: sim/tb_fractional_uart_baud_generator.sv
// testbench: apb register scenarios and measured tick spacing
// assumes a one-clock design with the uart model on its baud outputs
`default_nettype none

module tb_fractional_uart_baud_generator
  import baud_gen_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, timers_free, split, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic [15:0] gap, ticks;
  legacy_src_t legacy = '0;
  baud_out_t   baud;
  int          n_errors = 0, n_checks = 0;

  always #2.5 pclk = ~pclk;

  fractional_uart_baud_generator fractional_uart_baud_generator_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .legacy(legacy), .baud(baud), .timers_free(timers_free));
  uart_shift_model uart_shift_model_inst (.pclk(pclk), .presetn(presetn), .baud(baud),
    .gap(gap), .ticks(ticks), .split(split));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // the slave answers with no wait state; pready ends the wait, or the bound of 50 as an error
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int i = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin n_errors++; results(); end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wait_ticks(input int n);
    int i = 0;
    logic [15:0] t0 = ticks;
    while (ticks !== t0 + n[15:0] && i < 20000) begin @(posedge pclk); i++; end
    if (i >= 20000) begin n_errors++; results(); end
  endtask : wait_ticks
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    apb(1'b0, ctrl_offset, 32'h0, 4'hF); chk(rd, 32'h0000_0000);
    apb(1'b0, frac_offset, 32'h0, 4'hF); chk(rd, 32'h0000_0000);
    apb(1'b0, status_offset, 32'h0, 4'hF); chk(rd, 32'h0000_0000);
    chk({31'h0, baud.from_generator}, 32'h0);
  endtask : t_reset

  task automatic t_regs;
    apb(1'b1, frac_offset, 32'h0000_00A5, 4'hF);
    apb(1'b1, frac_offset, 32'h0000_005A, 4'h0);
    apb(1'b0, frac_offset, 32'h0, 4'hF); chk(rd, 32'h0000_00A5);
    apb(1'b1, ctrl_offset, 32'h0000_007F, 4'hF);
    apb(1'b0, ctrl_offset, 32'h0, 4'hF); chk(rd, 32'h0000_0007);
    apb(1'b0, 12'hFFC, 32'h0, 4'hF); chk({er, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, status_offset, 32'h0, 4'hF); chk({31'h0, er}, 32'h1);
  endtask : t_regs

  // legacy inputs all active: with the generator on they must change nothing
  task automatic t_enable;
    legacy <= '1;
    apb(1'b1, frac_offset, 32'h0000_0020, 4'hF);
    apb(1'b1, ctrl_offset, 32'h0000_0081, 4'hF);
    repeat (2) @(posedge pclk);
    chk({30'h0, baud.from_generator, timers_free}, 32'h3);
    wait_ticks(3);
    chk({16'h0, gap}, 32'd96);
    chk({31'h0, split}, 32'h0);
    apb(1'b0, status_offset, 32'h0, 4'hF); chk(rd, 32'h0000_0003);
  endtask : t_enable

  // exponent 0, fraction 0 started from stop: steady spacing of 32 clocks
  task automatic t_base;
    apb(1'b1, frac_offset, 32'h0000_0000, 4'hF);
    apb(1'b1, ctrl_offset, 32'h0000_0080, 4'hF);
    wait_ticks(3);
    chk({16'h0, gap}, 32'd32);
    apb(1'b1, ctrl_offset, 32'h0000_0000, 4'hF);
  endtask : t_base

  task automatic t_divs;
    apb(1'b1, frac_offset, 32'h0000_0008, 4'hF);
    for (int e = 0; e < 8; e++) begin
      apb(1'b1, ctrl_offset, 32'h80 | e, 4'hF);
      wait_ticks(3);
      chk({16'h0, gap}, 32'd36 << e);
    end
    apb(1'b1, ctrl_offset, 32'h0000_0000, 4'hF);
    repeat (2) @(posedge pclk);
    chk({30'h0, baud.from_generator, timers_free}, 32'h0);
  endtask : t_divs

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_regs();
    t_enable();
    t_divs();
    t_base();
    results();
  end
endmodule : tb_fractional_uart_baud_generator

`default_nettype wire
